// file: pkg/fifo_flags_pkg.sv
// Constants shared by the flag FIFO core, its flag unit and the flag interface.
// Assumes one 250 MHz clock for both FIFO ports and a 32-bit classic Wishbone bus.
package fifo_flags_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int                DEPTH      = 256;
  localparam int                ADDR_W     = 8;
  localparam int                LVL_W      = 9;
  localparam int                DATA_W     = 18;
  localparam int                OFS_W      = 12;
  localparam logic [ADDR_W-1:0] LAST_ADDR  = 8'hFF;
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 8'h00;
  localparam logic [LVL_W-1:0]  FULL_LEVEL = 9'h100;
  localparam logic [LVL_W-1:0]  HALF_LEVEL = 9'h080;

  // Offset loaded into both thresholds at reset, chosen by depth variant
  localparam logic [OFS_W-1:0]  OFFSET_DEFAULT = (DEPTH == 256) ? 12'h01F :
                                                 (DEPTH == 512) ? 12'h03F : 12'h07F;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int               WB_ADR_W   = 8;
  localparam logic [7:0]       REG_CTRL   = 8'h00;
  localparam logic [7:0]       REG_AE_OFS = 8'h04;
  localparam logic [7:0]       REG_AF_OFS = 8'h08;
  localparam logic [7:0]       REG_STATUS = 8'h0C;
  localparam logic [7:0]       REG_MASK   = 8'h10;
  localparam logic [7:0]       REG_LEVEL  = 8'h14;

  // CTRL fields
  localparam int               CTRL_EXPAND_BIT = 0;
  localparam logic [31:0]      CTRL_RESET      = 32'h0000_0000;

  // STATUS / MASK fields
  localparam int               EVT_W        = 6;
  localparam int               EVT_EMPTY    = 0;
  localparam int               EVT_AEMPTY   = 1;
  localparam int               EVT_AFULL    = 2;
  localparam int               EVT_FULL     = 3;
  localparam int               EVT_WR_DROP  = 4;
  localparam int               EVT_RD_DROP  = 5;
  localparam logic [EVT_W-1:0] MASK_RESET   = 6'h00;

  // LEVEL register: fill count low, live flags from this bit up
  localparam int               LEVEL_FLAGS_POS = 16;

endpackage : fifo_flags_pkg

// file: pkg/flag_if.sv
// Interface carrying fill level and thresholds to the flag unit, and flags back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface flag_if;
  import fifo_flags_pkg::*;

  logic [LVL_W-1:0] level_nxt;
  logic [OFS_W-1:0] ae_off;
  logic [OFS_W-1:0] af_off;
  logic             empty_n;
  logic             aempty_n;
  logic             afull_n;
  logic             full_n;
  logic             half_n;

  modport source (output level_nxt, ae_off, af_off,
                  input  empty_n, aempty_n, afull_n, full_n, half_n);
  modport flags  (input  level_nxt, ae_off, af_off,
                  output empty_n, aempty_n, afull_n, full_n, half_n);
endinterface : flag_if

// file: rtl/flag_unit.sv
// Registered status flags derived from the next fill level and the thresholds.
// Assumes level_nxt is the level the FIFO holds after the current edge.
`timescale 1ns/1ps
module flag_unit (
  input wire logic clock,
  input wire logic rst,
  flag_if.flags    fl
);
  import fifo_flags_pkg::*;

  // ****************************************************************
  // Threshold compares
  // ****************************************************************
  logic [LVL_W-1:0] free_nxt;
  logic             empty_nxt;
  logic             aempty_nxt;
  logic             afull_nxt;
  logic             full_nxt;
  logic             half_nxt;

  // Offsets are 12 bits wide, so compare in 13 bits to avoid truncating them
  assign free_nxt   = FULL_LEVEL - fl.level_nxt;
  assign empty_nxt  = (fl.level_nxt != '0);
  assign aempty_nxt = ({4'h0, fl.level_nxt} > {1'b0, fl.ae_off});
  assign afull_nxt  = ({4'h0, free_nxt} > {1'b0, fl.af_off});
  assign full_nxt   = (fl.level_nxt != FULL_LEVEL);
  assign half_nxt   = !(fl.level_nxt > HALF_LEVEL);

  // ****************************************************************
  // Flag registers
  // ****************************************************************
  // Flags clear as soon as the level moves back, on the edge that moved it
  always_ff @(posedge clock) begin
    if (rst) begin
      fl.empty_n  <= 1'b0;
      fl.aempty_n <= 1'b0;
      fl.afull_n  <= 1'b1;
      fl.full_n   <= 1'b1;
      fl.half_n   <= 1'b1;
    end else begin
      fl.empty_n  <= empty_nxt;
      fl.aempty_n <= aempty_nxt;
      fl.afull_n  <= afull_nxt;
      fl.full_n   <= full_nxt;
      fl.half_n   <= half_nxt;
    end
  end

endmodule : flag_unit

// file: rtl/flag_fifo.sv
// FIFO core with status flags, depth-chain pulses and a Wishbone register file.
// Assumes both FIFO ports are synchronous to CLOCK and inputs need no synchroniser.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps

// Function
// - Empty flag low while no word stored; reads then ignored.
// - Empty flag changes only on rising clock edges.
// - Almost-empty flag low when level within almost-empty offset.
// - Almost-empty offset resets to 31, 63 or 127 by depth.
// - Almost-full flag low when free space within almost-full offset.
// - Almost-full offset resets to 31, 63 or 127 by depth.
// - Outside chain mode, shared pin low when more than half full.
// - Chain mode: pulse write chain output when last location written.
// - Chain mode: pulse read chain output when last location read.
// - Read data leaves on an 18-bit bus like the write data.
// - Full flag low when all locations taken; writes then ignored.
// - Reset rewinds pointers, full flags high, empty flags low.
module flag_fifo
  import fifo_flags_pkg::*;
(
  input  wire logic                          CLOCK,
  input  wire logic                          RESET,
  input  wire logic                          MASTER_RESET_N,
  input  wire logic                          CHAIN_HEAD_SELECT_N,
  input  wire logic                          WRITE_EN_N,
  input  wire logic [fifo_flags_pkg::DATA_W-1:0] WRITE_DATA,
  input  wire logic                          READ_EN_N,
  output logic      [fifo_flags_pkg::DATA_W-1:0] READ_DATA_OUT,
  output logic                               EMPTY_FLAG_N,
  output logic                               ALMOST_EMPTY_FLAG_N,
  output logic                               ALMOST_FULL_FLAG_N,
  output logic                               FULL_FLAG_N,
  output logic                               WRITE_CHAIN_OUT_N,
  input  wire logic                          WRITE_CHAIN_IN_N,
  output logic                               READ_CHAIN_OUT_N,
  input  wire logic                          READ_CHAIN_IN_N,
  input  wire logic                          CYC_I,
  input  wire logic                          STB_I,
  input  wire logic                          WE_I,
  input  wire logic [fifo_flags_pkg::WB_ADR_W-1:0] ADR_I,
  input  wire logic [3:0]                    SEL_I,
  input  wire logic [31:0]                   DAT_I,
  output logic      [31:0]                   DAT_O,
  output logic                               ACK_O,
  output logic                               IRQ
);
  import fifo_flags_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic              rst;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr_r;
  logic [ADDR_W-1:0] rd_ptr_r;
  logic [LVL_W-1:0]  cnt_r;
  logic [LVL_W-1:0]  cnt_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_word;
  logic              wr_tok_r;
  logic              rd_tok_r;
  logic              wxo_r;
  logic              rxo_r;
  logic              expand;
  logic              wr_ok;
  logic              rd_ok;
  logic              wr_last;
  logic              rd_last;
  logic [31:0]       ctrl_r;
  logic [OFS_W-1:0]  ae_off_r;
  logic [OFS_W-1:0]  af_off_r;
  logic [EVT_W-1:0]  status_r;
  logic [EVT_W-1:0]  status_nxt;
  logic [EVT_W-1:0]  mask_r;
  logic [EVT_W-1:0]  evt;
  logic [EVT_W-1:0]  st_clr;
  logic [3:0]        flags_q_r;
  logic [3:0]        flags_now;
  logic              ack_r;
  logic [31:0]       dat_o_r;
  logic              wb_req;
  logic              wb_wr;
  logic [31:0]       rd_mux;
  logic [31:0]       level_word;
  logic [31:0]       lane_mask;

  flag_if fl ();

  // Master reset pin and system reset both return the block to its start state
  assign rst = RESET || !MASTER_RESET_N;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_merge = (old_v & ~m) | (new_v & m);
  endfunction : lane_merge

  // ****************************************************************
  // Port qualification
  // ****************************************************************
  // In chain mode only the device holding a token may move its pointer
  assign expand  = ctrl_r[CTRL_EXPAND_BIT];
  assign wr_ok   = !WRITE_EN_N && fl.full_n && (wr_tok_r || !expand);
  assign rd_ok   = !READ_EN_N && fl.empty_n && (rd_tok_r || !expand);
  assign wr_last = expand && wr_ok && (wr_ptr_r == LAST_ADDR);
  assign rd_last = expand && rd_ok && (rd_ptr_r == LAST_ADDR);
  assign cnt_nxt = LVL_W'(cnt_r + {8'h00, wr_ok} - {8'h00, rd_ok});
  assign rd_word = mem[rd_ptr_r];

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  // Array left without reset so it maps onto plain RAM
  always_ff @(posedge CLOCK) begin
    if (wr_ok) begin
      mem[wr_ptr_r] <= WRITE_DATA;
    end
  end

  // Pointers and level; both clocks are CLOCK so flags share its edges
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      wr_ptr_r <= FIRST_ADDR;
      rd_ptr_r <= FIRST_ADDR;
      cnt_r    <= '0;
    end else begin
      if (wr_ok) wr_ptr_r <= ADDR_W'(wr_ptr_r + 1'b1);
      if (rd_ok) rd_ptr_r <= ADDR_W'(rd_ptr_r + 1'b1);
      cnt_r <= cnt_nxt;
    end
  end

  // Output register holds the last word when no read is taken
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (rd_ok) begin
      rdata_r <= rd_word;
    end
  end

  // ****************************************************************
  // Depth chain tokens and pulses
  // ****************************************************************
  // Head device starts with both tokens; the head pin is caught at reset
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      wr_tok_r <= !CHAIN_HEAD_SELECT_N;
      rd_tok_r <= !CHAIN_HEAD_SELECT_N;
      wxo_r    <= 1'b1;
      rxo_r    <= 1'b1;
    end else begin
      wxo_r <= !wr_last;
      rxo_r <= !rd_last;
      if (wr_last) wr_tok_r <= 1'b0;
      else if (!WRITE_CHAIN_IN_N) wr_tok_r <= 1'b1;
      if (rd_last) rd_tok_r <= 1'b0;
      else if (!READ_CHAIN_IN_N) rd_tok_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Flag unit
  // ****************************************************************
  assign fl.level_nxt = cnt_nxt;
  assign fl.ae_off    = ae_off_r;
  assign fl.af_off    = af_off_r;

  flag_unit u_flags (
    .clock (CLOCK),
    .rst   (rst),
    .fl    (fl.flags)
  );

  // Shared pin: half-full outside chain mode, write chain pulse inside it
  assign WRITE_CHAIN_OUT_N   = expand ? wxo_r : fl.half_n;
  assign READ_CHAIN_OUT_N    = rxo_r;
  assign EMPTY_FLAG_N        = fl.empty_n;
  assign ALMOST_EMPTY_FLAG_N = fl.aempty_n;
  assign ALMOST_FULL_FLAG_N  = fl.afull_n;
  assign FULL_FLAG_N         = fl.full_n;
  assign READ_DATA_OUT       = rdata_r;

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  // A flag event is its falling edge; refused accesses are events too
  assign flags_now = {fl.full_n, fl.afull_n, fl.aempty_n, fl.empty_n};
  assign evt[3:0]  = flags_q_r & ~flags_now;
  assign evt[EVT_WR_DROP] = !WRITE_EN_N && !wr_ok;
  assign evt[EVT_RD_DROP] = !READ_EN_N && !rd_ok;
  assign lane_mask  = lane_merge(32'h0000_0000, 32'hFFFF_FFFF, SEL_I);
  assign st_clr     = (wb_wr && ADR_I == REG_STATUS) ? EVT_W'(DAT_I & lane_mask) : '0;
  // Set wins over clear so an event in the clearing cycle survives
  assign status_nxt = (status_r & ~st_clr) | evt;
  assign IRQ        = |(status_r & mask_r);

  always_ff @(posedge CLOCK) begin
    if (rst) begin
      flags_q_r <= 4'hC;                                                // Reset flag levels, no false edge
      status_r  <= '0;
    end else begin
      flags_q_r <= flags_now;
      status_r  <= status_nxt;
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // Writes land on the edge where ACK_O is seen high, so each takes once
  assign wb_req     = CYC_I && STB_I;
  assign wb_wr      = wb_req && WE_I && ack_r;
  assign level_word = {12'h000, flags_now, 7'h00, cnt_r};
  assign rd_mux     = (ADR_I == REG_CTRL)   ? ctrl_r :
                      (ADR_I == REG_AE_OFS) ? {20'h00000, ae_off_r} :
                      (ADR_I == REG_AF_OFS) ? {20'h00000, af_off_r} :
                      (ADR_I == REG_STATUS) ? {26'h0000000, status_r} :
                      (ADR_I == REG_MASK)   ? {26'h0000000, mask_r} :
                      (ADR_I == REG_LEVEL)  ? level_word : 32'h0000_0000;
  assign ACK_O = ack_r;
  assign DAT_O = dat_o_r;

  // One-cycle acknowledge; unmapped addresses answer with zero
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      ack_r   <= 1'b0;
      dat_o_r <= '0;
    end else begin
      ack_r   <= wb_req && !ack_r;
      dat_o_r <= (wb_req && !ack_r) ? rd_mux : dat_o_r;
    end
  end

  // Software registers; thresholds return to the variant default at reset
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      ctrl_r   <= CTRL_RESET;
      ae_off_r <= OFFSET_DEFAULT;
      af_off_r <= OFFSET_DEFAULT;
      mask_r   <= MASK_RESET;
    end else if (wb_wr) begin
      if (ADR_I == REG_CTRL)
        ctrl_r <= lane_merge(ctrl_r, DAT_I, SEL_I) & 32'h0000_0001;
      if (ADR_I == REG_AE_OFS)
        ae_off_r <= OFS_W'(lane_merge({20'h00000, ae_off_r}, DAT_I, SEL_I));
      if (ADR_I == REG_AF_OFS)
        af_off_r <= OFS_W'(lane_merge({20'h00000, af_off_r}, DAT_I, SEL_I));
      if (ADR_I == REG_MASK)
        mask_r <= EVT_W'(lane_merge({26'h0000000, mask_r}, DAT_I, SEL_I));
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (rst);

  sequence last_write_s;
    expand && wr_ok && (wr_ptr_r == LAST_ADDR);
  endsequence
  sequence last_read_s;
    expand && rd_ok && (rd_ptr_r == LAST_ADDR);
  endsequence
  sequence low_pulse_w_s;
    !WRITE_CHAIN_OUT_N ##1 (WRITE_CHAIN_OUT_N || !expand);
  endsequence
  sequence low_pulse_r_s;
    !READ_CHAIN_OUT_N ##1 READ_CHAIN_OUT_N;
  endsequence

  empty_blocks_a: assert property (!EMPTY_FLAG_N && !READ_EN_N |=> $stable(rd_ptr_r))
    else $error("read taken while empty");
  empty_level_a: assert property ((cnt_r == '0) == !EMPTY_FLAG_N)
    else $error("empty flag disagrees with level");
  aempty_thr_a: assert property (1'b1 |=> ALMOST_EMPTY_FLAG_N ==
      ({4'h0, $past(cnt_nxt)} > {1'b0, $past(ae_off_r)}))
    else $error("almost-empty flag wrong");
  ae_default_a: assert property ($fell(RESET) && MASTER_RESET_N |-> ae_off_r == OFFSET_DEFAULT)
    else $error("almost-empty offset not default");
  afull_thr_a: assert property (1'b1 |=> ALMOST_FULL_FLAG_N ==
      ({4'h0, LVL_W'(FULL_LEVEL - $past(cnt_nxt))} > {1'b0, $past(af_off_r)}))
    else $error("almost-full flag wrong");
  af_default_a: assert property ($fell(RESET) && MASTER_RESET_N |-> af_off_r == OFFSET_DEFAULT)
    else $error("almost-full offset not default");
  half_full_a: assert property (!expand |-> WRITE_CHAIN_OUT_N == !(cnt_r > HALF_LEVEL))
    else $error("half-full output wrong");
  wr_chain_a: assert property (last_write_s |=> low_pulse_w_s)
    else $error("no write chain pulse");
  rd_chain_a: assert property (last_read_s |=> low_pulse_r_s)
    else $error("no read chain pulse");
  read_data_a: assert property (rd_ok |=> READ_DATA_OUT == $past(rd_word))
    else $error("read data not presented");
  full_blocks_a: assert property (!FULL_FLAG_N && !WRITE_EN_N |=> $stable(wr_ptr_r))
    else $error("write taken while full");
  reset_state_a: assert property (@(posedge CLOCK) disable iff (1'b0) rst |=>
      FULL_FLAG_N && ALMOST_FULL_FLAG_N
      && !EMPTY_FLAG_N && !ALMOST_EMPTY_FLAG_N && wr_ptr_r == FIRST_ADDR && rd_ptr_r == FIRST_ADDR)
    else $error("reset state wrong");
  full_release_a: assert property (!FULL_FLAG_N && rd_ok |=> FULL_FLAG_N)
    else $error("full flag not released");

endmodule : flag_fifo

// file: verif/chain_peer.sv
// Neighbour model at the far end of the depth chain, closing a one-device ring.
// Assumes the FIFO shares its clock and that each chain out pulse is low for one cycle.
`timescale 1ns/1ps
module chain_peer #(
  parameter int DLY = 7
) (
  input  wire logic clock,
  input  wire logic wr_out_n,
  input  wire logic rd_out_n,
  output logic      wr_in_n,
  output logic      rd_in_n
);
  // ****************************************************************
  // Token return
  // ****************************************************************
  logic [1:0] prev_r = 2'h3;
  int         wcnt_r = 0;
  int         rcnt_r = 0;

  // A falling chain out starts a countdown, so the token comes back late, not at once
  always @(posedge clock) begin
    prev_r <= {wr_out_n, rd_out_n};
    wcnt_r <= (prev_r[1] && !wr_out_n) ? DLY : ((wcnt_r > 0) ? wcnt_r - 1 : 0);
    rcnt_r <= (prev_r[0] && !rd_out_n) ? DLY : ((rcnt_r > 0) ? rcnt_r - 1 : 0);
  end

  // Return pulses last exactly one cycle
  assign wr_in_n = (wcnt_r != 1);
  assign rd_in_n = (rcnt_r != 1);
endmodule : chain_peer

// file: verif/test_flag_fifo.sv
// Self-checking bench for flag_fifo: fill, drain, random traffic, registers, chain.
// Assumes chain_peer closes the token ring of a single chained device.
`timescale 1ns/1ps
module test_flag_fifo;
  import fifo_flags_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; time due;} note_t;
  // ****************************************************************
  // Stimulus, observation and bookkeeping
  // ****************************************************************
  logic                clock  = 1'h0;
  logic                reset  = 1'h1;
  logic                mrst_n = 1'h1;
  logic                wen_n  = 1'h1;
  logic                ren_n  = 1'h1;
  logic [DATA_W-1:0]   wdata  = 18'h0;
  logic                cyc    = 1'h0;
  logic                stb    = 1'h0;
  logic                we     = 1'h0;
  logic [WB_ADR_W-1:0] adr    = 8'h00;
  logic [31:0]         dat_i  = 32'h0;
  logic [DATA_W-1:0]   rdata;
  logic [31:0]         dat_o;
  logic                empty_n, aempty_n, afull_n, full_n, wco_n, rco_n;
  logic                wci_n, rci_n, ack, irq;
  wire  [31:0]         obs;
  integer              seed = 32'h632C8A2A;
  int                  n_mismatch = 0;
  int                  cmp_count = 0;
  int                  lvl = 0, wp = 0, rp = 0, ae = 31, af = 31;
  bit                  chain = 1'b0;
  logic [DATA_W-1:0]   mem_q[$];
  note_t               fq[$], bq[$];

  // Pins packed as {data, empty, aempty, afull, full, chain out, chain read out, irq}
  assign obs = {7'h00, rdata, empty_n, aempty_n, afull_n, full_n, wco_n, rco_n, irq};

  flag_fifo u_flag_fifo (
    .CLOCK(clock), .RESET(reset), .MASTER_RESET_N(mrst_n), .CHAIN_HEAD_SELECT_N(1'h0),
    .WRITE_EN_N(wen_n), .WRITE_DATA(wdata), .READ_EN_N(ren_n), .READ_DATA_OUT(rdata),
    .EMPTY_FLAG_N(empty_n), .ALMOST_EMPTY_FLAG_N(aempty_n), .ALMOST_FULL_FLAG_N(afull_n),
    .FULL_FLAG_N(full_n), .WRITE_CHAIN_OUT_N(wco_n), .WRITE_CHAIN_IN_N(wci_n),
    .READ_CHAIN_OUT_N(rco_n), .READ_CHAIN_IN_N(rci_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .IRQ(irq));

  chain_peer u_chain_peer (.clock(clock), .wr_out_n(wco_n), .rd_out_n(rco_n),
                           .wr_in_n(wci_n), .rd_in_n(rci_n));

  // 250 MHz clock
  always #2 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] expv(input logic [DATA_W-1:0] d, input logic wc,
                                       input logic rc);
    expv = {7'h00, d, lvl != 0, lvl > ae, (DEPTH - lvl) > af, lvl != DEPTH, wc, rc, 1'h0};
  endfunction : expv

  // One FIFO port cycle; the level model decides what the design must accept
  task automatic op(input bit w, input bit r);
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] q;
    bit                wa;
    bit                ra;
    note_t             nt;
    d  = DATA_W'($random(seed));
    q  = 18'h0;
    wa = w && lvl < DEPTH;
    ra = r && lvl > 0;
    nt.m = {7'h00, ra ? 18'h3FFFF : 18'h0, 7'h7E};
    if (ra) q = mem_q.pop_front();
    if (wa) mem_q.push_back(d);
    lvl = lvl + int'(wa) - int'(ra);
    nt.v = expv(q, chain ? !(wa && wp == DEPTH - 1) : !(lvl > DEPTH / 2),
                !(chain && ra && rp == DEPTH - 1));
    wp = (wp + int'(wa)) % DEPTH;
    rp = (rp + int'(ra)) % DEPTH;
    nt.due = $time + 4;
    fq.push_back(nt);
    wen_n <= !w;
    ren_n <= !r;
    wdata <= d;
    @(posedge clock);
  endtask : op

  // Classic Wishbone cycle: held until ack, released after it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic [31:0] m);
    note_t nt;
    nt.v   = e;
    nt.m   = m;
    nt.due = 0;
    bq.push_back(nt);
    cyc   <= 1'h1;
    stb   <= 1'h1;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    // Only the watchdog ends a wait for the acknowledge
    do begin
      @(posedge clock);
    end while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clock);
  endtask : wb

  // Results are judged half a cycle after their edge, once settled
  always @(negedge clock) begin : watch
    note_t nt;
    if (ack === 1'h1 && bq.size() > 0) begin
      nt = bq.pop_front();
      check(dat_o & nt.m, nt.v & nt.m);
    end
    while (fq.size() > 0 && fq[0].due < $time) begin
      nt = fq.pop_front();
      check(obs & 32'h78, nt.v & 32'h78);
      check(obs & 32'h06, nt.v & 32'h06);
      check(obs & nt.m & ~32'h7F, nt.v & ~32'h7F);
    end
  end

  // Hang guard, far beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin : main
    int          i;
    logic [31:0] rv;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    @(negedge clock);
    check(obs, 32'h0000_001E);
    @(posedge clock);
    wb(1'h0, REG_AE_OFS, 32'h0, 32'h0000_001F, 32'hFFFF_FFFF);
    wb(1'h0, REG_AF_OFS, 32'h0, 32'h0000_001F, 32'hFFFF_FFFF);
    wb(1'h0, 8'h40, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wb(1'h1, REG_MASK, 32'h0000_003F, 32'h0, 32'h0);
    repeat (DEPTH + 1) op(1'b1, 1'b0);
    op(1'b0, 1'b0);
    wb(1'h0, REG_LEVEL, 32'h0, 32'h0003_0100, 32'hFFFF_FFFF);
    wb(1'h0, REG_STATUS, 32'h0, 32'h0000_001C, 32'hFFFF_FFFF);
    check({31'h0, irq}, 32'h1);
    wb(1'h1, REG_STATUS, 32'h0000_001C, 32'h0, 32'h0);
    check({31'h0, irq}, 32'h0);
    repeat (DEPTH + 1) op(1'b0, 1'b1);
    op(1'b0, 1'b0);
    wb(1'h0, REG_STATUS, 32'h0, 32'h0000_0023, 32'hFFFF_FFFF);
    wb(1'h1, REG_MASK, 32'h0, 32'h0, 32'h0);
    check({31'h0, irq}, 32'h0);
    wb(1'h1, REG_STATUS, 32'h0000_003F, 32'h0, 32'h0);
    wb(1'h1, REG_AE_OFS, 32'h0000_0005, 32'h0, 32'h0);
    wb(1'h1, REG_AF_OFS, 32'h0000_000A, 32'h0, 32'h0);
    ae = 5;
    af = 10;
    for (i = 0; i < 600; i++) begin
      rv = $random(seed);
      if (i < 300) op(rv[1:0] != 2'h0, rv[3:2] == 2'h0);
      else op(rv[3:2] == 2'h0, rv[1:0] != 2'h0);
    end
    op(1'b0, 1'b0);
    mrst_n <= 1'h0;
    @(posedge clock);
    mrst_n <= 1'h1;
    lvl = 0;
    wp  = 0;
    rp  = 0;
    ae  = 31;
    af  = 31;
    mem_q.delete();
    @(negedge clock);
    check(obs, 32'h0000_001E);
    @(posedge clock);
    wb(1'h0, REG_AE_OFS, 32'h0, 32'h0000_001F, 32'hFFFF_FFFF);
    wb(1'h1, REG_CTRL, 32'h0000_0001, 32'h0, 32'h0);
    chain = 1'b1;
    repeat (DEPTH + 1) op(1'b1, 1'b0);
    op(1'b0, 1'b0);
    repeat (20) @(posedge clock);
    repeat (DEPTH) op(1'b0, 1'b1);
    op(1'b0, 1'b0);
    repeat (20) @(posedge clock);
    report_and_stop();
  end
endmodule : test_flag_fifo
